// ==== logic/esu_pin_drv.sv ====
`timescale 1ns/1ps
`default_nettype none
module esu_pin_drv (
	input wire logic serial_port_enable_i,
	input wire logic drive_i,
	input wire logic value_i,
	input wire logic open_drain_i,
	output logic out_o,
	output logic oe_o
);
	import esu_pkg::*;
	wire own_w = serial_port_enable_i & drive_i;
	assign out_o = open_drain_i ? 1'b0 : value_i; // RQ9
	assign oe_o = own_w & ~(open_drain_i & value_i); // RQ9 RQ10
endmodule : esu_pin_drv
`default_nettype wire

// ==== logic/esu_pkg.sv ====
package esu_pkg;
	// ==========================================
	// register map (byte addresses, one word each)
	localparam logic [3:0] ESU_ADDR_TX_CTRL = 4'h0;
	localparam logic [3:0] ESU_ADDR_RX_CTRL = 4'h4;
	localparam logic [3:0] ESU_ADDR_BAUD = 4'h8;
	localparam logic [3:0] ESU_ADDR_DATA = 4'hC;
	// ==========================================
	// tx control fields
	localparam int ESU_TX_CLK_MASTER = 7;
	localparam int ESU_TX_ENABLE = 5;
	localparam int ESU_TX_SYNC = 4;
	localparam int ESU_TX_BREAK = 3;
	localparam int ESU_TX_IDLE = 1;
	// ==========================================
	// rx control fields
	localparam int ESU_RX_PORT_EN = 7;
	localparam int ESU_RX_SINGLE = 5;
	localparam int ESU_RX_CONT = 4;
	localparam int ESU_RX_FRAME_ERR = 2;
	localparam int ESU_RX_OVERRUN = 1;
	localparam int ESU_RX_VALID = 0;
	// ==========================================
	// baud control fields
	localparam int ESU_BD_AUTO_BAUD = 0;
	localparam int ESU_BD_WAKE = 1;
	localparam int ESU_BD_CLK_POL = 4;
	localparam int ESU_BD_WAKE_FLAG = 7;
	localparam int ESU_BD_DIV_LSB = 16;
	localparam int ESU_DIV_W = 16;
	localparam logic [15:0] ESU_DIV_RESET = 16'h0010;
	// ==========================================
	// framing
	localparam logic [3:0] ESU_CHAR_BITS = 4'hA;
	localparam logic [3:0] ESU_BREAK_BITS = 4'hD;
	localparam logic [7:0] ESU_BREAK_DATA = 8'h00;
	localparam logic [7:0] ESU_SYNC_CHAR = 8'h55;
	localparam logic [31:0] ESU_UNMAPPED = 32'h00000000;

	typedef struct packed {
		logic in;
		logic out;
		logic oe;
	} esu_pin_t;
endpackage : esu_pkg

// ==== logic/esu_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// Operation
// (RQ1) async mode transmits and receives at the same time.
// (RQ2) sync half-duplex as clock master or slave, selectable clock polarity.
// (RQ3) async transmitter can send a 12-bit break character.
// (RQ4) async mode can flag wake on a received sync break.
// (RQ5) async mode can measure the incoming baud rate automatically.
// (RQ6) software sets serial port enable before pins carry traffic.
// (RQ7) software makes both port C shared pins inputs so the unit owns them.
// (RQ8) the unit switches each owned pin between input and output per mode.
// (RQ9) open-drain select makes the transmit pin only pull low.
// (RQ10) with serial port enable clear the unit drives neither pin.
module esu_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic port_c_direction_7_i,
	input wire logic port_c_direction_6_i,
	input wire logic tx_open_drain_select_i,
	input wire logic transmit_pin_i,
	output esu_pkg::esu_pin_t transmit_pin_o,
	input wire logic receive_pin_i,
	output esu_pkg::esu_pin_t receive_pin_o,
	output logic wake_o
);
	import esu_pkg::*;
	typedef enum logic [1:0] {ESU_IDLE, ESU_SHIFT} esu_st_t;
	// ==========================================
	// registers
	logic [7:0] tx_ctrl_r, rx_ctrl_r, baud_ctrl_r;
	logic [ESU_DIV_W-1:0] div_r, brk_cnt_r;
	logic [7:0] tx_data_r, rx_data_r, tx_sh_r, rx_sh_r;
	logic tx_pend_r, rx_valid_r, ack_r, tx_busy_r, tx_brk_r;
	esu_st_t tx_st_r, rx_st_r;
	logic [3:0] tx_bit_r, rx_bit_r;
	logic [ESU_DIV_W-1:0] tx_cnt_r, rx_cnt_r;
	logic tx_line_r, sclk_r, rx_q_r, rx_err_r, ovr_r;
	// ==========================================
	// bus decode
	wire req_w = wb_cyc_i & wb_stb_i & ~ack_r;
	// writes land at the edge that sees ack high, with the request still held
	wire wr_w = wb_cyc_i & wb_stb_i & ack_r & wb_we_i & wb_sel_i[0];
	wire wr_tx_w = wr_w & (wb_adr_i == ESU_ADDR_TX_CTRL);
	wire wr_rx_w = wr_w & (wb_adr_i == ESU_ADDR_RX_CTRL);
	wire wr_bd_w = wr_w & (wb_adr_i == ESU_ADDR_BAUD);
	wire wr_dat_w = wr_w & (wb_adr_i == ESU_ADDR_DATA);
	wire rd_dat_w = req_w & ~wb_we_i & (wb_adr_i == ESU_ADDR_DATA);
	wire serial_port_enable_w = rx_ctrl_r[ESU_RX_PORT_EN]; // RQ6
	wire sync_w = tx_ctrl_r[ESU_TX_SYNC];
	wire master_w = tx_ctrl_r[ESU_TX_CLK_MASTER];
	wire pol_w = baud_ctrl_r[ESU_BD_CLK_POL];
	wire owned_w = serial_port_enable_w & port_c_direction_7_i & port_c_direction_6_i; // RQ7
	wire [7:0] tx_st_bits_w = {tx_ctrl_r[7:2], ~tx_busy_r, tx_ctrl_r[0]};
	wire [7:0] rx_st_bits_w = {rx_ctrl_r[7:3], rx_err_r, ovr_r, rx_valid_r};
	logic [31:0] rd_w;
	always_comb begin
		case (wb_adr_i)
		ESU_ADDR_TX_CTRL: rd_w = {24'h000000, tx_st_bits_w};
		ESU_ADDR_RX_CTRL: rd_w = {24'h000000, rx_st_bits_w};
		ESU_ADDR_BAUD: rd_w = {div_r, 8'h00, baud_ctrl_r};
		ESU_ADDR_DATA: rd_w = {24'h000000, rx_data_r};
		default: rd_w = ESU_UNMAPPED;
		endcase
	end
	assign wb_ack_o = ack_r;
	// ==========================================
	// bit timing: one enable per bit period
	wire tx_tick_w = (tx_cnt_r == div_r);
	wire half_w = (rx_cnt_r == (div_r >> 1));
	wire rx_tick_w = (rx_cnt_r == div_r);
	// sync: data pin shares the receive pin, clock on the transmit pin
	wire sdin_w = receive_pin_i;
	wire rxin_w = sync_w ? 1'b1 : receive_pin_i;
	wire slave_edge_w = sync_w & ~master_w & (transmit_pin_i ^ pol_w) & ~sclk_r; // RQ2
	wire tx_start_w = tx_st_r == ESU_IDLE & tx_pend_r & tx_ctrl_r[ESU_TX_ENABLE] & owned_w;
	logic [ESU_DIV_W-1:0] low_cnt_r;
	wire fall_w = rx_q_r & ~rxin_w;
	wire abd_done_w = baud_ctrl_r[ESU_BD_AUTO_BAUD] & ~rx_q_r & rxin_w & (low_cnt_r != 16'h0000);
	wire [ESU_DIV_W-1:0] abd_div_w = low_cnt_r - 16'h0001;
	wire wake_set_w = baud_ctrl_r[ESU_BD_WAKE] & fall_w & ~sync_w;
	assign wake_o = baud_ctrl_r[ESU_BD_WAKE_FLAG];
	wire rx_en_w = owned_w & (rx_ctrl_r[ESU_RX_CONT] | rx_ctrl_r[ESU_RX_SINGLE]);
	// ==========================================
	// bus and control
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			wb_dat_o <= 32'h00000000;
			tx_ctrl_r <= 8'h00;
			rx_ctrl_r <= 8'h00;
			baud_ctrl_r <= 8'h00;
			div_r <= ESU_DIV_RESET;
			tx_data_r <= 8'h00;
			tx_pend_r <= 1'b0;
		end else begin
			ack_r <= req_w;
			if (req_w)
				wb_dat_o <= rd_w;
			if (wr_tx_w)
				tx_ctrl_r <= wb_dat_i[7:0];
			else if (tx_start_w)
				tx_ctrl_r[ESU_TX_BREAK] <= 1'b0; // RQ3
			if (wr_rx_w)
				rx_ctrl_r <= wb_dat_i[7:0];
			if (wr_bd_w) begin
				baud_ctrl_r <= wb_dat_i[7:0];
				if (wb_sel_i[3:2] == 2'h3)
					div_r <= wb_dat_i[31:16];
			end else if (abd_done_w) begin
				baud_ctrl_r[ESU_BD_AUTO_BAUD] <= 1'b0; // RQ5
				div_r <= abd_div_w;
			end
			if (wake_set_w)
				baud_ctrl_r[ESU_BD_WAKE_FLAG] <= 1'b1; // RQ4
			if (wr_dat_w) begin
				tx_data_r <= wb_dat_i[7:0];
				tx_pend_r <= 1'b1;
			end else if (tx_start_w)
				tx_pend_r <= 1'b0;
		end
	end
	// ==========================================
	// transmitter: async frame or sync shift, independent of receiver
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_st_r <= ESU_IDLE;
			tx_cnt_r <= 16'h0000;
			tx_bit_r <= 4'h0;
			tx_sh_r <= 8'h00;
			tx_line_r <= 1'b1;
			tx_busy_r <= 1'b0;
			tx_brk_r <= 1'b0;
			sclk_r <= 1'b0;
		end else begin
			sclk_r <= transmit_pin_i ^ pol_w;
			case (tx_st_r)
			ESU_IDLE: begin
				tx_line_r <= 1'b1;
				tx_busy_r <= 1'b0;
				if (tx_start_w) begin
					tx_st_r <= ESU_SHIFT; // RQ1
					tx_brk_r <= tx_ctrl_r[ESU_TX_BREAK] & ~sync_w; // RQ3
					tx_sh_r <= tx_ctrl_r[ESU_TX_BREAK] ? ESU_BREAK_DATA : tx_data_r;
					tx_bit_r <= 4'h0;
					tx_cnt_r <= 16'h0000;
					tx_busy_r <= 1'b1;
					tx_line_r <= sync_w ? tx_data_r[0] : 1'b0;
				end
			end
			ESU_SHIFT: begin
				tx_cnt_r <= tx_tick_w ? 16'h0000 : tx_cnt_r + 16'h0001;
				if ((sync_w & ~master_w) ? slave_edge_w : tx_tick_w) begin
					tx_bit_r <= tx_bit_r + 4'h1;
					if (sync_w) begin
						tx_sh_r <= {1'b0, tx_sh_r[7:1]};
						tx_line_r <= tx_sh_r[1];
						if (tx_bit_r == 4'h7)
							tx_st_r <= ESU_IDLE;
					end else if (tx_brk_r) begin
						tx_line_r <= (tx_bit_r >= ESU_BREAK_BITS - 4'h2); // RQ3
						if (tx_bit_r == ESU_BREAK_BITS - 4'h1)
							tx_st_r <= ESU_IDLE;
					end else begin
						tx_line_r <= (tx_bit_r < 4'h8) ? tx_sh_r[0] : 1'b1;
						tx_sh_r <= {1'b1, tx_sh_r[7:1]};
						if (tx_bit_r == ESU_CHAR_BITS - 4'h1)
							tx_st_r <= ESU_IDLE;
					end
				end
			end
			default: tx_st_r <= ESU_IDLE;
			endcase
		end
	end
	// ==========================================
	// receiver with auto-baud (low time of start bit) and wake detect
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_st_r <= ESU_IDLE;
			rx_q_r <= 1'b1;
			rx_cnt_r <= 16'h0000;
			rx_bit_r <= 4'h0;
			rx_sh_r <= 8'h00;
			rx_data_r <= 8'h00;
			rx_valid_r <= 1'b0;
			rx_err_r <= 1'b0;
			ovr_r <= 1'b0;
			low_cnt_r <= 16'h0000;
		end else begin
			rx_q_r <= rxin_w;
			low_cnt_r <= (~rxin_w & ~sync_w) ? low_cnt_r + 16'h0001 : 16'h0000;
			if (rd_dat_w)
				rx_valid_r <= 1'b0;
			case (rx_st_r)
			ESU_IDLE: begin
				rx_cnt_r <= 16'h0000;
				rx_bit_r <= 4'h0;
				// sync frame starts with the transmit shift so no stray frame follows it
				if (rx_en_w & ~baud_ctrl_r[ESU_BD_AUTO_BAUD] & (sync_w ? tx_start_w : fall_w))
					rx_st_r <= ESU_SHIFT; // RQ1
			end
			ESU_SHIFT: begin
				rx_cnt_r <= rx_tick_w ? 16'h0000 : rx_cnt_r + 16'h0001;
				if (sync_w ? tx_tick_w : half_w) begin
					rx_bit_r <= rx_bit_r + 4'h1;
					if (rx_bit_r != 4'h0 | sync_w)
						rx_sh_r <= {sdin_w, rx_sh_r[7:1]};
					if (rx_bit_r == (sync_w ? 4'h7 : ESU_CHAR_BITS - 4'h1)) begin
						rx_st_r <= ESU_IDLE;
						rx_data_r <= sync_w ? {sdin_w, rx_sh_r[7:1]} : rx_sh_r;
						rx_err_r <= ~sync_w & ~rxin_w;
						ovr_r <= ovr_r | rx_valid_r;
						rx_valid_r <= 1'b1; // set wins over read clear
					end
				end
			end
			default: rx_st_r <= ESU_IDLE;
			endcase
		end
	end
	// ==========================================
	// pin direction: async tx drives, sync master drives clock
	wire tx_drv_w = ~sync_w | master_w; // RQ8
	// sync clock idles at the polarity level, active half in the second half of each bit
	wire clk_act_w = (tx_cnt_r >= (div_r >> 1)) & (tx_st_r == ESU_SHIFT);
	wire tx_val_w = sync_w ? (clk_act_w ^ pol_w) : tx_line_r; // RQ2
	wire rx_drv_w = sync_w & (tx_st_r == ESU_SHIFT); // RQ8
	esu_pin_drv u_tx_drv (
		.serial_port_enable_i(owned_w),
		.drive_i(tx_drv_w),
		.value_i(tx_val_w),
		.open_drain_i(tx_open_drain_select_i),
		.out_o(transmit_pin_o.out),
		.oe_o(transmit_pin_o.oe)
	);
	esu_pin_drv u_rx_drv (
		.serial_port_enable_i(owned_w),
		.drive_i(rx_drv_w),
		.value_i(tx_line_r),
		.open_drain_i(1'b0),
		.out_o(receive_pin_o.out),
		.oe_o(receive_pin_o.oe)
	);
	assign transmit_pin_o.in = transmit_pin_i;
	assign receive_pin_o.in = receive_pin_i;
	// ==========================================
	// assertions
	sequence s_req;
		req_w;
	endsequence
	a_bus_ack_next: assert property (@(posedge clk_i) disable iff (rst_i) s_req |=> wb_ack_o) else $error("ack missing");
	a_pins_released: assert property (@(posedge clk_i) disable iff (rst_i) !owned_w |-> !transmit_pin_o.oe && !receive_pin_o.oe) else $error("pin driven while disabled"); // RQ10
	a_od_no_high: assert property (@(posedge clk_i) disable iff (rst_i) tx_open_drain_select_i && transmit_pin_o.oe |-> !transmit_pin_o.out) else $error("open drain drove high"); // RQ9
	a_break_clears: assert property (@(posedge clk_i) disable iff (rst_i) tx_start_w && !wr_tx_w |=> !tx_ctrl_r[ESU_TX_BREAK]) else $error("break request stuck"); // RQ3
	a_async_tx_owned: assert property (@(posedge clk_i) disable iff (rst_i) owned_w && !sync_w |-> transmit_pin_o.oe || tx_open_drain_select_i) else $error("async tx not driven"); // RQ8
	a_sync_data_dir: assert property (@(posedge clk_i) disable iff (rst_i) owned_w && sync_w && tx_st_r == ESU_SHIFT |-> receive_pin_o.oe) else $error("sync data not driven"); // RQ2
	a_wake_flag: assert property (@(posedge clk_i) disable iff (rst_i) wake_set_w |=> wake_o) else $error("wake not flagged"); // RQ4
	a_autobaud_load: assert property (@(posedge clk_i) disable iff (rst_i) abd_done_w && !wr_bd_w |=> div_r == $past(abd_div_w) && !baud_ctrl_r[ESU_BD_AUTO_BAUD]) else $error("auto baud not loaded"); // RQ5
endmodule : esu_top
`default_nettype wire

// ==== testbench/esu_peer.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// serial peer: pull-ups on both lines, frames lsb first
module esu_peer (
	input wire logic clk_i,
	input wire esu_pkg::esu_pin_t tx_i,
	input wire esu_pkg::esu_pin_t rx_i,
	output logic tx_wire_o,
	output logic rx_wire_o
);
	import esu_pkg::*;
	logic drv_r = 1'b0;
	logic val_r = 1'b1;
	assign tx_wire_o = tx_i.oe ? tx_i.out : 1'b1;
	assign rx_wire_o = rx_i.oe ? rx_i.out : (drv_r ? val_r : 1'b1);
	task automatic put(input logic v, input int n);
		drv_r <= 1'b1;
		val_r <= v;
		repeat (n) @(posedge clk_i);
	endtask : put
	task automatic send(input logic [7:0] b, input int bc);
		put(1'b0, bc);
		for (int i = 0; i < 8; i++) put(b[i], bc);
		put(1'b1, bc);
		drv_r <= 1'b0;
	endtask : send
	task automatic hunt();
		int n;
		n = 0;
		while (tx_wire_o !== 1'b0 && n < 2000) begin
			@(posedge clk_i);
			n++;
		end
	endtask : hunt
	task automatic grab(output logic [7:0] b, input int bc);
		hunt();
		repeat (bc + bc / 2) @(posedge clk_i);
		for (int i = 0; i < 8; i++) begin
			b[i] = tx_wire_o;
			repeat (bc) @(posedge clk_i);
		end
	endtask : grab
	task automatic sync_grab(output logic [7:0] b, input logic pol);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_i);
			while (tx_wire_o === pol) @(posedge clk_i);
			b[i] = rx_wire_o;
			while (tx_wire_o !== pol) @(posedge clk_i);
		end
	endtask : sync_grab
	task automatic low_run(output int n);
		hunt();
		n = 0;
		while (tx_wire_o === 1'b0 && n < 500) begin
			@(posedge clk_i);
			n++;
		end
	endtask : low_run
endmodule : esu_peer
`default_nettype wire

// ==== testbench/esu_top_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module esu_top_test;
	import esu_pkg::*;
	typedef struct packed {
		logic we;
		logic [3:0] a;
		logic [31:0] d;
		logic [31:0] m;
		logic [31:0] e;
	} esu_row_t;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, wake, tx_w, rx_w;
	logic d7 = 1'b1, d6 = 1'b1, od = 1'b0, i0;
	logic [3:0] adr = 4'h0, sel = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, q;
	logic [7:0] got;
	int error_cnt = 0, checks_done = 0, n;
	esu_pin_t tx_p, rx_p;
	esu_row_t rows [8] = '{
		{1'b0, ESU_ADDR_BAUD, 32'h0, 32'hFFFF0000, 32'h00100000},
		{1'b1, 4'h2, 32'hFF, 32'h0, 32'h0},
		{1'b0, 4'h2, 32'h0, 32'hFFFFFFFF, 32'h0},
		{1'b1, ESU_ADDR_BAUD, 32'h00030000, 32'h0, 32'h0},
		{1'b0, ESU_ADDR_BAUD, 32'h0, 32'hFFFF0000, 32'h00030000},
		{1'b1, ESU_ADDR_RX_CTRL, 32'h90, 32'h0, 32'h0},
		{1'b1, ESU_ADDR_TX_CTRL, 32'h20, 32'h0, 32'h0},
		{1'b0, ESU_ADDR_TX_CTRL, 32'h0, 32'hB8, 32'h20}};
	always #2.5 clk_i = ~clk_i;
	esu_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.port_c_direction_7_i(d7), .port_c_direction_6_i(d6), .tx_open_drain_select_i(od),
		.transmit_pin_i(tx_w), .transmit_pin_o(tx_p), .receive_pin_i(rx_w),
		.receive_pin_o(rx_p), .wake_o(wake));
	esu_peer peer (.clk_i(clk_i), .tx_i(tx_p), .rx_i(rx_p), .tx_wire_o(tx_w), .rx_wire_o(rx_w));
	task automatic chk_w(input string s, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask : chk_w
	task automatic chk_b(input string s, input logic e, input logic g);
		chk_w(s, {31'h0, e}, {31'h0, g});
	endtask : chk_b
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hF;
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task automatic settle();
		repeat (2) @(posedge clk_i);
	endtask : settle
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : give_verdict
	initial begin
		#100000;
		error_cnt++;
		give_verdict();
	end
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		settle();
		chk_b("tx oe off", 1'b0, tx_p.oe);
		chk_b("rx oe off", 1'b0, rx_p.oe);
		chk_b("wake off", 1'b0, wake);
		foreach (rows[i]) begin
			wb(rows[i].we, rows[i].a, rows[i].d);
			if (rows[i].m !== 32'h0) chk_w("row", rows[i].e, q & rows[i].m);
		end
		settle();
		chk_b("tx owned", 1'b1, tx_p.oe);
		chk_b("rx input", 1'b0, rx_p.oe);
		d6 <= 1'b0;
		settle();
		chk_b("tx not owned", 1'b0, tx_p.oe);
		d6 <= 1'b1;
		od <= 1'b1;
		settle();
		chk_b("od idle float", 1'b0, tx_p.oe);
		fork
			peer.grab(got, 4);
			peer.send(8'h3C, 4);
			wb(1'b1, ESU_ADDR_DATA, 32'hA5);
			begin
				peer.hunt();
				#1;
				chk_b("od pulls low", 1'b1, tx_p.oe & ~tx_p.out);
			end
		join
		od <= 1'b0;
		chk_w("tx byte", 32'hA5, {24'h0, got});
		wb(1'b0, ESU_ADDR_RX_CTRL, 32'h0);
		chk_w("rx valid", 32'h1, q & 32'h1);
		wb(1'b0, ESU_ADDR_DATA, 32'h0);
		chk_w("rx byte", 32'h3C, q & 32'hFF);
		$display("test pins and duplex done");
		fork
			peer.low_run(n);
			begin
				wb(1'b1, ESU_ADDR_TX_CTRL, 32'h28);
				wb(1'b1, ESU_ADDR_DATA, {24'h0, ESU_BREAK_DATA});
			end
		join
		chk_w("break 12 bits", 32'h00000030, n);
		settle();
		wb(1'b0, ESU_ADDR_TX_CTRL, 32'h0);
		chk_w("break clears", 32'h0, q & 32'h08);
		wb(1'b1, ESU_ADDR_BAUD, 32'h00030001);
		peer.send(ESU_SYNC_CHAR, 8);
		repeat (20) @(posedge clk_i);
		wb(1'b0, ESU_ADDR_BAUD, 32'h0);
		chk_w("auto baud", 32'h00070000, q & 32'hFFFF0001);
		wb(1'b1, ESU_ADDR_BAUD, 32'h00070002);
		peer.put(1'b0, 104);
		peer.send(ESU_SYNC_CHAR, 8);
		repeat (20) @(posedge clk_i);
		chk_b("wake flag", 1'b1, wake);
		wb(1'b1, ESU_ADDR_BAUD, 32'h00070000);
		settle();
		chk_b("wake cleared", 1'b0, wake);
		$display("test break baud wake done");
		wb(1'b1, ESU_ADDR_TX_CTRL, 32'hB0);
		settle();
		i0 = tx_p.out;
		chk_b("master clock", 1'b1, tx_p.oe);
		wb(1'b1, ESU_ADDR_BAUD, 32'h00070010);
		settle();
		chk_b("polarity", 1'b1, i0 !== tx_p.out);
		fork
			peer.sync_grab(got, 1'b1);
			wb(1'b1, ESU_ADDR_DATA, 32'hA5);
		join
		chk_w("sync tx byte", 32'hA5, {24'h0, got});
		wb(1'b0, ESU_ADDR_DATA, 32'h0);
		chk_w("sync rx byte", 32'hA5, q & 32'hFF);
		wb(1'b1, ESU_ADDR_TX_CTRL, 32'h30);
		settle();
		chk_b("slave clock in", 1'b0, tx_p.oe);
		wb(1'b1, ESU_ADDR_RX_CTRL, 32'h0);
		settle();
		chk_b("release tx", 1'b0, tx_p.oe);
		chk_b("release rx", 1'b0, rx_p.oe);
		chk_b("tx pin echo", tx_w, tx_p.in);
		chk_b("rx pin echo", rx_w, rx_p.in);
		$display("test sync and release done");
		give_verdict();
	end
endmodule : esu_top_test
`default_nettype wire
